// [verilog/gcr_pkg.sv]
package gcr_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [6:0] GCR_ADDR_GLOBAL_CONFIGURATION = 7'h00; // Register address
   localparam logic [7:0] GCR_WRITE_OFFSET = 8'h80; // Added to address on writes
   localparam int GCR_CFG_WIDTH = 10; // Defined bits of the register

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int GCR_BIT_ANALOG_REF = 0; // Reference pin voltage select
   localparam int GCR_BIT_INTERNAL_SENSE = 1; // Internal sense resistors
   localparam int GCR_BIT_CHOPPER_MODE = 2; // chopper_mode_select
   localparam int GCR_BIT_SHAFT_INVERT = 3; // Direction inversion
   localparam int GCR_BIT_INDEX_OTPW = 4; // Index shows prewarning
   localparam int GCR_BIT_INDEX_STEP = 5; // Index toggles on steps
   localparam int GCR_BIT_PIN_STBY_OFF = 6; // Single-wire pin standby input off
   localparam int GCR_BIT_RES_FROM_REG = 7; // Resolution from register field
   localparam int GCR_BIT_STEP_FILTER = 8; // Step pulse filtering
   localparam int GCR_BIT_TEST_MODE = 9; // Analog test mode

   // ---------------------------------------------------------------
   // Reset values (bits 1 and 2 come from one-time-programmable memory)
   // ---------------------------------------------------------------
   localparam logic [9:0] GCR_RESET_VALUE = 10'h101;
   localparam logic [9:0] GCR_OTP_MASK = 10'h006;

   // ---------------------------------------------------------------
   // Host command state machine
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      GCR_H_IDLE = 2'b00,
      GCR_H_WRITE = 2'b01,
      GCR_H_READ = 2'b10,
      GCR_H_WAIT = 2'b11
   } gcr_host_state_t;
endpackage

// [verilog/gcr_link_if.sv]
// Register access link between host and device.
interface gcr_link_if;
   logic req; // Access request, one-cycle pulse
   logic [7:0] addr; // Address, bit 7 set marks a write
   logic [31:0] wdata; // Write data
   logic ack; // Answer pulse
   logic [31:0] rdata; // Read data, valid with ack

   modport device (input req, input addr, input wdata, output ack, output rdata);
   modport host (output req, output addr, output wdata, input ack, input rdata);
endinterface

// [verilog/gcr_index_sel.sv]
// Index output selection, registered.
module gcr_index_sel (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic index_otpw_i, // Field: prewarning on index
   input wire logic index_step_i, // Field: step toggling on index
   input wire logic first_step_pos_i, // Sequencer at first microstep
   input wire logic otpw_flag_i, // Overtemperature prewarning
   input wire logic pulse_gen_step_i, // Internal pulse generator step
   output logic index_o
);
   // ---------------------------------------------------------------
   // Toggle and output select
   // ---------------------------------------------------------------
   logic toggle_q; // Step toggle flop
   logic toggle_d;
   logic index_q;
   logic index_d;

   // Next-value logic
   always_comb begin
      toggle_d = toggle_q ^ pulse_gen_step_i;
      if (index_step_i) begin
         index_d = toggle_d;
      end else if (index_otpw_i) begin
         index_d = otpw_flag_i;
      end else begin
         index_d = first_step_pos_i;
      end
   end

   // Registers
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         toggle_q <= 1'b0;
         index_q <= 1'b0;
      end else begin
         toggle_q <= toggle_d;
         index_q <= index_d;
      end
   end

   assign index_o = index_q;
endmodule

// [verilog/gcr_device.sv]
module gcr_device
   import gcr_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   gcr_link_if.device link,
   input wire logic [1:0] otp_bits_i, // OTP defaults for bits 1 and 2
   input wire logic chopper_mode_pin_i, // Chopper mode inversion pin
   input wire logic dir_i, // Direction input
   input wire logic first_step_pos_i, // Sequencer at first microstep
   input wire logic otpw_flag_i, // Overtemperature prewarning
   input wire logic pulse_gen_step_i, // Internal pulse generator step
   input wire logic pin_standby_i, // Standby request on single-wire pin
   input wire logic resolution_pin_a_i,
   input wire logic resolution_pin_b_i,
   input wire logic [1:0] mstep_field_i, // Resolution from register field
   input wire logic enable_low_pin_i, // Driver enable, active low
   input wire logic [1:0] hold_current_field_i, // Low bits of hold current field
   input wire logic [2:0] diag_sources_i, // Internal signals for diag pin
   output logic analog_ref_sel_o,
   output logic internal_sense_o,
   output logic ref_pin_ground_o,
   output logic chopper_cycle_mode_o, // Effective chopper mode
   output logic dir_eff_o,
   output logic index_o,
   output logic standby_req_o,
   output logic [1:0] resolution_o,
   output logic step_filter_en_o,
   output logic test_output_en_o,
   output logic enable_pulldown_o,
   output logic driver_enabled_o,
   output logic diag_clock_pin_o
);
   // ---------------------------------------------------------------
   // Register and bus answer state
   // ---------------------------------------------------------------
   logic [GCR_CFG_WIDTH-1:0] cfg_q; // global_configuration
   logic [GCR_CFG_WIDTH-1:0] cfg_d;
   logic ack_q;
   logic ack_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic otp_load_q; // One cycle after reset release
   logic otp_load_d;
   logic hit_wr; // Write to this register
   logic hit_rd; // Read of this register

   // Address decode
   // A write carries the register address with the write offset added;
   // a read carries the plain address. Any other address is still
   // answered, but nothing is stored and the read data stays zero.
   always_comb begin
      hit_wr = link.req && (link.addr == (GCR_WRITE_OFFSET | {1'b0, GCR_ADDR_GLOBAL_CONFIGURATION}));
      hit_rd = link.req && (link.addr == {1'b0, GCR_ADDR_GLOBAL_CONFIGURATION});
   end

   // Next register values
   // The two bits backed by one-time-programmable memory are loaded one
   // cycle after reset release. A host write in that same cycle wins,
   // because it is applied later in this process.
   always_comb begin
      // Hold by default, no answer unless a request came in
      cfg_d = cfg_q;
      otp_load_d = 1'b0;
      ack_d = link.req; // Every request answered next cycle
      rdata_d = 32'h0000_0000;
      // Defaults for internal sense and chopper mode
      if (otp_load_q) begin
         cfg_d[GCR_BIT_INTERNAL_SENSE] = otp_bits_i[0];
         cfg_d[GCR_BIT_CHOPPER_MODE] = otp_bits_i[1];
      end
      // Host write replaces all ten bits, bits above are dropped
      if (hit_wr) begin
         cfg_d = link.wdata[GCR_CFG_WIDTH-1:0];
      end
      // Read data, bits above the register read as zero
      if (hit_rd) begin
         rdata_d = {{(32-GCR_CFG_WIDTH){1'b0}}, cfg_q};
      end
   end

   // Registers, reset to documented values then OTP load
   // Reset is synchronous and loads constants only.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         // Documented defaults, OTP-backed bits follow a cycle later
         cfg_q <= GCR_RESET_VALUE;
         otp_load_q <= 1'b1;
         ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         cfg_q <= cfg_d;
         otp_load_q <= otp_load_d;
         ack_q <= ack_d;
         rdata_q <= rdata_d;
      end
   end

   // Bus answer, straight from flip-flops
   assign link.ack = ack_q;
   assign link.rdata = rdata_q;

   // ---------------------------------------------------------------
   // Field effects
   // ---------------------------------------------------------------
   logic [12:0] out_d; // Next output values, bit 12 is the diag pin
   logic [11:0] out_q; // Registered outputs
   logic test_mode; // Test mode bit of the register

   // Decoded outputs
   // Every output is registered: a field change shows one cycle after it
   // lands in the register, a pin input one cycle after it moves.
   always_comb begin
      test_mode = cfg_q[GCR_BIT_TEST_MODE];
      out_d = '0;
      // Reference and sense resistor selection
      out_d[0] = cfg_q[GCR_BIT_ANALOG_REF];
      out_d[1] = cfg_q[GCR_BIT_INTERNAL_SENSE];
      out_d[2] = cfg_q[GCR_BIT_INTERNAL_SENSE];
      // Chopper mode, a high pin inverts the select bit
      out_d[3] = cfg_q[GCR_BIT_CHOPPER_MODE] ^ chopper_mode_pin_i;
      // Direction and standby request
      out_d[4] = dir_i ^ cfg_q[GCR_BIT_SHAFT_INVERT];
      out_d[5] = pin_standby_i && !cfg_q[GCR_BIT_PIN_STBY_OFF];
      // Microstep resolution from the register field or the pins
      if (cfg_q[GCR_BIT_RES_FROM_REG]) begin
         out_d[7:6] = mstep_field_i;
      end else begin
         out_d[7:6] = {resolution_pin_b_i, resolution_pin_a_i};
      end
      // Step pulse filter
      out_d[8] = cfg_q[GCR_BIT_STEP_FILTER];
      // Test mode: analog output on the enable pin, pull-down off,
      // driver treated as enabled
      out_d[9] = test_mode;
      out_d[10] = !test_mode;
      out_d[11] = test_mode || !enable_low_pin_i;
      // Diag pin source chosen by hold current bits in test mode
      case (hold_current_field_i)
         2'b00: out_d[12] = diag_sources_i[0];
         2'b01: out_d[12] = diag_sources_i[1];
         2'b10: out_d[12] = diag_sources_i[2];
         default: out_d[12] = 1'b0;
      endcase
      // Diag pin held low outside test mode
      out_d[12] = out_d[12] && test_mode;
   end

   logic diag_q; // Diag pin flop

   // ---------------------------------------------------------------
   // Output registers
   // ---------------------------------------------------------------
   // Reset leaves the reference pin selected and the enable pull-down on
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         out_q <= 12'h401;
         diag_q <= 1'b0;
      end else begin
         out_q <= out_d[11:0];
         diag_q <= out_d[12];
      end
   end

   // Top-level outputs, each straight from a flip-flop
   assign analog_ref_sel_o = out_q[0];
   assign internal_sense_o = out_q[1];
   assign ref_pin_ground_o = out_q[2];
   assign chopper_cycle_mode_o = out_q[3];
   assign dir_eff_o = out_q[4];
   assign standby_req_o = out_q[5];
   assign resolution_o = out_q[7:6];
   assign step_filter_en_o = out_q[8];
   assign test_output_en_o = out_q[9];
   assign enable_pulldown_o = out_q[10];
   assign driver_enabled_o = out_q[11];
   assign diag_clock_pin_o = diag_q;

   // ---------------------------------------------------------------
   // Index output
   // ---------------------------------------------------------------
   // Step toggling and the source select live in a helper module
   gcr_index_sel u_index (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .index_otpw_i(cfg_q[GCR_BIT_INDEX_OTPW]),
      .index_step_i(cfg_q[GCR_BIT_INDEX_STEP]),
      .first_step_pos_i(first_step_pos_i),
      .otpw_flag_i(otpw_flag_i),
      .pulse_gen_step_i(pulse_gen_step_i),
      .index_o(index_o)
   );
endmodule

// [verilog/gcr_host.sv]
module gcr_host
   import gcr_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   gcr_link_if.host link,
   input wire logic cmd_valid_i, // Command strobe
   input wire logic cmd_write_i, // 1 write, 0 read
   input wire logic [6:0] cmd_addr_i, // Register address
   input wire logic [31:0] cmd_wdata_i,
   input wire logic motor_standstill_i, // Motor at standstill
   output logic cmd_ready_o,
   output logic done_o, // Completion pulse
   output logic refused_o, // Command refused pulse
   output logic [31:0] rdata_o
);
   // ---------------------------------------------------------------
   // Command state
   // ---------------------------------------------------------------
   gcr_host_state_t st_q;
   gcr_host_state_t st_d;
   logic req_q, req_d;
   logic [7:0] addr_q, addr_d;
   logic [31:0] wdata_q, wdata_d;
   logic ready_q, ready_d;
   logic done_q, done_d;
   logic refused_q, refused_d;
   logic [31:0] rdata_q, rdata_d;
   logic [31:0] safe_wdata; // Write data with policy applied
   logic [GCR_CFG_WIDTH-1:0] shadow_q, shadow_d; // Last written config
   logic silent_on; // Write turns silent mode from off to on
   logic is_cfg;

   // Next state
   always_comb begin
      st_d = st_q;
      req_d = 1'b0;
      addr_d = addr_q;
      wdata_d = wdata_q;
      ready_d = ready_q;
      done_d = 1'b0;
      refused_d = 1'b0;
      rdata_d = rdata_q;
      shadow_d = shadow_q;
      is_cfg = (cmd_addr_i == GCR_ADDR_GLOBAL_CONFIGURATION);
      safe_wdata = cmd_wdata_i;
      if (is_cfg) begin
         safe_wdata[GCR_BIT_PIN_STBY_OFF] = 1'b1;
         safe_wdata[GCR_BIT_TEST_MODE] = 1'b0;
      end
      silent_on = is_cfg && shadow_q[GCR_BIT_CHOPPER_MODE] && !cmd_wdata_i[GCR_BIT_CHOPPER_MODE];
      case (st_q)
         GCR_H_IDLE: begin
            if (cmd_valid_i && cmd_write_i && silent_on && !motor_standstill_i) begin
               refused_d = 1'b1;
            end else if (cmd_valid_i) begin
               req_d = 1'b1;
               ready_d = 1'b0;
               wdata_d = safe_wdata;
               if (cmd_write_i) begin
                  addr_d = GCR_WRITE_OFFSET | {1'b0, cmd_addr_i};
                  if (is_cfg) begin
                     shadow_d = safe_wdata[GCR_CFG_WIDTH-1:0];
                  end
                  st_d = GCR_H_WRITE;
               end else begin
                  addr_d = {1'b0, cmd_addr_i};
                  st_d = GCR_H_READ;
               end
            end
         end
         GCR_H_WRITE, GCR_H_READ: begin
            st_d = GCR_H_WAIT;
         end
         GCR_H_WAIT: begin
            if (link.ack) begin
               done_d = 1'b1;
               ready_d = 1'b1;
               rdata_d = link.rdata;
               st_d = GCR_H_IDLE;
            end
         end
         default: st_d = GCR_H_IDLE;
      endcase
   end

   // Registers
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         st_q <= GCR_H_IDLE;
         req_q <= 1'b0;
         addr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         ready_q <= 1'b1;
         done_q <= 1'b0;
         refused_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         shadow_q <= GCR_RESET_VALUE | GCR_OTP_MASK;
      end else begin
         st_q <= st_d;
         req_q <= req_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         ready_q <= ready_d;
         done_q <= done_d;
         refused_q <= refused_d;
         rdata_q <= rdata_d;
         shadow_q <= shadow_d;
      end
   end

   assign link.req = req_q;
   assign link.addr = addr_q;
   assign link.wdata = wdata_q;
   assign cmd_ready_o = ready_q;
   assign done_o = done_q;
   assign refused_o = refused_q;
   assign rdata_o = rdata_q;
endmodule

// [bench/gcr_link_properties.sv]
// Link watcher: answer timing, read-back and host write shaping
module gcr_link_properties (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic req_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic ack_i,
   input wire logic [31:0] rdata_i
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----
   // Shadow of the last write that reached the register
   // ----
   logic [9:0] shadow_q; // Last written value
   logic [9:0] shadow_d;
   logic seen_q; // A write landed since reset
   logic seen_d;
   // Next shadow state
   always_comb begin
      shadow_d = shadow_q;
      seen_d = seen_q;
      if (req_i && addr_i == 8'h80) begin
         shadow_d = wdata_i[9:0];
         seen_d = 1'b1;
      end
   end
   // Shadow registers, cleared to zero by reset, unlike the device register
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         shadow_q <= 10'h000;
         seen_q <= 1'b0;
      end else begin
         shadow_q <= shadow_d;
         seen_q <= seen_d;
      end
   end
   // ----
   // Properties
   // ----
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_answer;
      ack_i ##1 !ack_i;
   endsequence
   sequence s_read_written;
      req_i && addr_i == 8'h00 && seen_q;
   endsequence
   sequence s_read_fresh;
      req_i && addr_i == 8'h00 && !seen_q;
   endsequence
   a_ack_follows: assert property (req_i |=> s_answer) else $error("no single ack after request");
   a_no_stray_ack: assert property (ack_i |-> $past(req_i)) else $error("ack without request");
   a_upper_zero: assert property (ack_i |-> rdata_i[31:10] == 22'h0) else $error("upper bits not zero");
   a_read_back: assert property (s_read_written |=> rdata_i[9:0] == shadow_q)
      else $error("read-back differs");
   a_reset_value: assert property (s_read_fresh |=> (rdata_i[9:0] & 10'h3F9) == 10'h101)
      else $error("bad default");
   a_unmapped_zero: assert property (req_i && !addr_i[7] && addr_i[6:0] != 7'h00 |=> rdata_i == 32'h0)
      else $error("unmapped read not zero");
   a_bit6_forced: assert property (req_i && addr_i == 8'h80 |-> wdata_i[6]) else $error("bit 6 clear on write");
   a_test_kept_off: assert property (req_i && addr_i == 8'h80 |-> !wdata_i[9])
      else $error("test bit set on write");
endmodule

// [bench/tb_global_config_register.sv]
module tb_global_config_register
   import gcr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk_i = 1'b0; // 25 MHz system clock
   logic rst_n_i = 1'b0; // Synchronous reset, active low
   logic cmd_valid = 1'b0;
   logic cmd_write = 1'b0;
   logic [6:0] cmd_addr = 7'h00;
   logic [31:0] cmd_wdata = 32'h0;
   logic standstill = 1'b1; // Motor at standstill
   logic step = 1'b0; // Pulse generator step
   logic [1:0] otp = 2'b00; // OTP defaults
   logic [15:0] iv = 16'h0000; // Random device inputs
   logic cmd_ready, done, refused, last_ref, got;
   logic [31:0] rdata, tmp, seed = 32'h38;
   logic [9:0] cfg; // Expected register content
   wire [13:0] o; // Device outputs, packed
   int err_count = 0;
   int check_count = 0;
   gcr_link_if link();
   gcr_host u_gcr_host (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .link(link), .cmd_valid_i(cmd_valid),
      .cmd_write_i(cmd_write), .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata), .motor_standstill_i(standstill),
      .cmd_ready_o(cmd_ready), .done_o(done), .refused_o(refused), .rdata_o(rdata));
   gcr_device u_gcr_device (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .link(link), .otp_bits_i(otp),
      .chopper_mode_pin_i(iv[0]), .dir_i(iv[1]), .first_step_pos_i(iv[2]), .otpw_flag_i(iv[3]),
      .pulse_gen_step_i(step), .pin_standby_i(iv[4]), .resolution_pin_a_i(iv[5]), .resolution_pin_b_i(iv[6]),
      .mstep_field_i(iv[8:7]), .enable_low_pin_i(iv[9]), .hold_current_field_i(iv[11:10]),
      .diag_sources_i(iv[14:12]), .analog_ref_sel_o(o[13]), .internal_sense_o(o[12]), .ref_pin_ground_o(o[11]),
      .chopper_cycle_mode_o(o[10]), .dir_eff_o(o[9]), .standby_req_o(o[8]), .resolution_o(o[7:6]),
      .step_filter_en_o(o[5]), .test_output_en_o(o[4]), .enable_pulldown_o(o[3]), .driver_enabled_o(o[2]),
      .diag_clock_pin_o(o[1]), .index_o(o[0]));
   gcr_link_properties u_gcr_link_properties (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_i(link.req),
      .addr_i(link.addr), .wdata_i(link.wdata), .ack_i(link.ack), .rdata_i(link.rdata));
   // Clock generator
   always #20 sys_clk_i = ~sys_clk_i;
   // ----
   // Helpers
   // ----
   // Repeatable xorshift source
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Register content after a host write
   function automatic logic [9:0] wr_val(input logic [31:0] d);
      return (d[9:0] | 10'h040) & 10'h1FF;
   endfunction
   // Outputs for a register value and inputs, index without step toggling
   function automatic logic [13:0] exp_out(input logic [9:0] c, input logic [15:0] v);
      return {c[0], c[1], c[1], c[2] ^ v[0], v[1] ^ c[3], v[4] & !c[6], c[7] ? v[8:7] : {v[6], v[5]},
         c[8], c[9], !c[9], c[9] | !v[9], (c[9] && v[11:10] != 2'b11) ? v[12 + v[11:10]] : 1'b0,
         c[4] ? v[3] : v[2]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t mismatch got %h want %h", $time, seen, exp);
      end
   endtask
   // One host command, waits for completion or refusal
   task automatic cmd(input logic wr, input logic [6:0] a, input logic [31:0] d);
      last_ref = 1'b0;
      got = 1'b0;
      @(posedge sys_clk_i);
      cmd_valid <= 1'b1;
      cmd_write <= wr;
      cmd_addr <= a;
      cmd_wdata <= d;
      @(posedge sys_clk_i);
      cmd_valid <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         #1;
         if (done === 1'b1 || refused === 1'b1) begin
            last_ref = (refused === 1'b1);
            got = 1'b1;
            break;
         end
         @(posedge sys_clk_i);
      end
      check(got, 1'b1);
      check(cmd_ready, 1'b1);
   endtask
   // New random inputs, then compare all outputs
   task automatic chk_out(input logic [9:0] c);
      @(posedge sys_clk_i);
      iv <= 16'(rnd());
      repeat (2) @(posedge sys_clk_i);
      #1;
      check(o, exp_out(c, iv));
   endtask
   // Reset, then read and compare the defaults
   task automatic do_reset();
      @(posedge sys_clk_i);
      rst_n_i <= 1'b0;
      tmp = rnd();
      otp <= tmp[1:0];
      repeat (12) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      cfg = 10'h101 | {7'h0, otp, 1'b0};
      cmd(1'b0, 7'h00, 32'h0);
      check(rdata, {22'h0, cfg});
      chk_out(cfg);
      $display("test reset done");
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ----
   // Main sequence and watchdog
   // ----
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      err_count++;
      complete_run();
   end
   initial begin
      do_reset();
      // Random writes with corner values first
      for (int n = 0; n < 24; n++) begin
         tmp = (n == 0) ? 32'h0 : (n == 1) ? 32'hFFFF_FFDF : rnd() & 32'hFFFF_FFDF;
         cmd(1'b1, 7'h00, tmp);
         cfg = wr_val(tmp);
         cmd(1'b0, 7'h00, 32'h0);
         check(rdata, {22'h0, cfg});
         chk_out(cfg);
      end
      $display("test random done");
      // Index toggles once per generator step
      cmd(1'b1, 7'h00, 32'h030);
      repeat (2) @(posedge sys_clk_i);
      #1;
      check(o[0], 1'b0);
      tmp = rnd() % 6 + 1;
      for (int j = 0; j < tmp; j++) begin
         @(posedge sys_clk_i);
         step <= 1'b1;
         @(posedge sys_clk_i);
         step <= 1'b0;
      end
      repeat (2) @(posedge sys_clk_i);
      #1;
      check(o[0], tmp[0]);
      $display("test index done");
      // Clearing the chopper bit while moving is refused, at standstill taken
      @(posedge sys_clk_i);
      standstill <= 1'b0;
      cmd(1'b1, 7'h00, 32'h004);
      check(last_ref, 1'b0);
      cmd(1'b1, 7'h00, 32'h000);
      check(last_ref, 1'b1);
      cmd(1'b0, 7'h00, 32'h0);
      check(rdata, {22'h0, wr_val(32'h004)});
      @(posedge sys_clk_i);
      standstill <= 1'b1;
      cmd(1'b1, 7'h00, 32'h000);
      check(last_ref, 1'b0);
      $display("test refusal done");
      // Unmapped address: ignored and read as zero
      cmd(1'b1, 7'h05, 32'h3FF);
      cmd(1'b0, 7'h05, 32'h0);
      check(rdata, 32'h0);
      cmd(1'b0, 7'h00, 32'h0);
      check(rdata, {22'h0, wr_val(32'h000)});
      $display("test unmapped done");
      do_reset();
      complete_run();
   end
endmodule
